// ### rtl/seq_pkg.sv
package seq_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int INIT_US = 308;
    localparam int OE_FILT_US = 16;
    localparam int BST_US = 8;
    localparam int SS_075_US = 750;
    localparam int SS_15_US = 1500;
    localparam int SS_3_US = 3000;
    localparam int SS_6_US = 6000;
    localparam int BLANK_SHORT_US = 125;
    localparam int BLANK_LONG_US = 2000;
    localparam int FAULT_FILT_CYC = 64;
    // Derived cycle counts
    localparam int INIT_CYC = INIT_US * CLK_MHZ;
    localparam int OE_FILT_CYC = OE_FILT_US * CLK_MHZ;
    localparam int BST_CYC = BST_US * CLK_MHZ;
    localparam int SS_075_CYC = SS_075_US * CLK_MHZ;
    localparam int SS_15_CYC = SS_15_US * CLK_MHZ;
    localparam int SS_3_CYC = SS_3_US * CLK_MHZ;
    localparam int SS_6_CYC = SS_6_US * CLK_MHZ;
    localparam int BLANK_SHORT_CYC = BLANK_SHORT_US * CLK_MHZ;
    localparam int BLANK_LONG_CYC = BLANK_LONG_US * CLK_MHZ;
    // ------------------------------------------------------------
    // Codes and encodings
    // ------------------------------------------------------------
    localparam logic [3:0] RCODE_MIN = 4'h1;
    localparam logic [3:0] RCODE_SPLIT = 4'h8;
    localparam logic [3:0] RCODE_MAX = 4'hC;
    localparam logic [3:0] RCODE_GAIN_B = 4'h4;
    localparam logic [3:0] ADDR_HIGH = 4'hA;
    localparam logic [1:0] SS_SEL_075 = 2'h0;
    localparam logic [1:0] SS_SEL_15 = 2'h1;
    localparam logic [1:0] SS_SEL_3 = 2'h2;
    localparam logic [1:0] SS_SEL_6 = 2'h3;
    localparam logic [1:0] CCODE_OPEN = 2'h0;
    localparam logic [1:0] CCODE_220P = 2'h1;
    localparam logic [1:0] CCODE_1000P = 2'h2;
    // Boot reference in mV and frequency in kHz
    localparam logic [9:0] BOOT_REFERENCE_LEVEL_OPEN_MV = 10'h288; // 648
    localparam logic [9:0] BOOT_REFERENCE_LEVEL_220_MV = 10'h382; // 898
    localparam logic [9:0] BOOT_REFERENCE_LEVEL_1000_MV = 10'h3E8; // 1000
    localparam logic [9:0] FSW_400 = 10'h190;
    localparam logic [9:0] FSW_600 = 10'h258;
    localparam logic [9:0] FSW_800 = 10'h320;
    // Gain in tenths of a milliohm
    localparam logic [5:0] GAIN_09 = 6'h09;
    localparam logic [5:0] GAIN_36 = 6'h24;
    localparam logic [5:0] GAIN_18 = 6'h12;
    localparam logic [15:0] REF_FULL = 16'hFFFF;

    // Latched programming settings
    typedef struct packed {
        logic [6:0] bus_address;
        logic [1:0] ss_sel;
        logic [9:0] boot_reference_level;
        logic [5:0] current_sense_gain;
        logic [1:0] ocp_setting;
        logic [9:0] fsw_khz;
    } prog_s;

    // Fault detector inputs
    typedef struct packed {
        logic output_undervoltage_detect;
        logic output_overvoltage_detect;
        logic valley_over_primary;
        logic valley_over_reduced;
        logic input_supply_low;
        logic vcc_low;
        logic over_temp_150;
        logic over_temp_130;
        logic bootstrap_fault;
        logic sense_fault;
    } fault_s;
endpackage : seq_pkg

// ### rtl/fault_filter.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Persistence filter: output follows input after a steady run
// ----------------------------------------------------------------
module fault_filter #(
    parameter int CYCLES = 64
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Raw and filtered level
    input wire logic raw,
    output logic filtered
);
    logic [15:0] cnt_q; // Run length of disagreement

    // Count cycles that raw differs from output; flip after CYCLES
    // R23 persistence count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
            filtered <= 1'b0;
        end else if (raw == filtered) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q == 16'(CYCLES - 1)) begin
            cnt_q <= 16'h0000;
            filtered <= raw;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // R23 filter persistence
    a_filter_persist: assert property (@(posedge clock) disable iff (rst)
        $rose(filtered) |-> $past(raw, 1) && $past(raw, 2)) // R23
        else $error("filter rose without persistent input");
endmodule : fault_filter

// ### rtl/regulator_startup_fault_sequencer.sv
`timescale 1ns/10ps
// Functional notes
// R1 - Initialize up to 308us before sampling enable
// R2 - Enable must hold high over 16us
// R3 - Charge bootstrap 8us before soft start
// R4 - Soft start 0.75/1.5/3/6ms linear reference ramp (code decodes only 1.5ms or 3ms from the first resistor code)
// R5 - Status releases after ramp plus blanking
// R6 - Internal enable is pin OR bus bit
// R7 - Host may enable via bus operate bit
// R8 - Regulate only once ramp passes residual
// R9 - Residual above target: switches off until ramp ends
// R10 - Undervoltage: status low, keep regulating
// R11 - Overvoltage: status low, stop until valid
// R12 - Valley overcurrent blocks high side, hysteresis
// R13 - Supply lockout stops switching, status low
// R14 - Overtemperature 150 or 130C, non-latching
// R15 - Shutdown faults restart via full startup
// R16 - Sense or bootstrap faults pull status low
// R17 - Status low while disabled, high in window
// R18 - Program pins latched once at power up
// R19 - First resistor code: soft start, address
// R20 - First capacitor code: boot reference
// R21 - Second resistor code: gain, overcurrent setting
// R22 - Second capacitor code: switching frequency
// R23 - Fault filters use fixed persistence count
// R24 - Enable loss aborts startup, returns waiting
module regulator_startup_fault_sequencer (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Enable sources and overtemperature trip level select
    input wire logic enable_pin,
    input wire logic bus_operate,
    input wire logic bus_otp_low_sel,
    // Programming pin codes from decoders
    input wire logic [3:0] first_pin_resistor_code,
    input wire logic [1:0] first_pin_capacitor_code,
    input wire logic [3:0] second_pin_resistor_code,
    input wire logic [1:0] second_pin_capacitor_code,
    // Blanking select and analog comparators
    input wire logic blank_long_sel,
    input wire logic residual_below_ref,
    input wire logic residual_above_target,
    input wire seq_pkg::fault_s faults,
    // Power stage control
    output logic bootstrap_node_charge,
    output logic switching_enable,
    output logic high_side_block,
    output logic reduced_current_limit,
    output logic [15:0] ref_ramp,
    // Status open-drain pin
    output logic status_out,
    output logic status_oe,
    // Latched settings
    output seq_pkg::prog_s prog
);
    import seq_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_meta_q; // First stage
    logic [2:0] pin_sync_q; // Second stage
    fault_s flt_meta_q;
    fault_s flt_q;

    // Two flops for pin and comparator inputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
            flt_meta_q <= '0;
            flt_q <= '0;
        end else begin
            pin_meta_q <= {enable_pin, residual_above_target, residual_below_ref};
            pin_sync_q <= pin_meta_q;
            flt_meta_q <= faults;
            flt_q <= flt_meta_q;
        end
    end

    logic en_pin_s;
    logic res_above_s;
    logic res_below_s; // Ramp above residual, synchronised
    assign en_pin_s = pin_sync_q[2];
    assign res_above_s = pin_sync_q[1];
    assign res_below_s = pin_sync_q[0];

    // R6 combined enable
    logic int_enable;
    assign int_enable = en_pin_s | bus_operate;

    // ------------------------------------------------------------
    // Fault filtering and grouping
    // ------------------------------------------------------------
    logic uv_f;
    logic ov_f;
    fault_filter #(.CYCLES(FAULT_FILT_CYC)) u_uv (
        .clock(clock), .rst(rst),
        .raw(flt_q.output_undervoltage_detect), .filtered(uv_f)
    );
    fault_filter #(.CYCLES(FAULT_FILT_CYC)) u_ov (
        .clock(clock), .rst(rst),
        .raw(flt_q.output_overvoltage_detect), .filtered(ov_f)
    );

    // R14 trip level select
    logic otp;
    assign otp = bus_otp_low_sel ? flt_q.over_temp_130 : flt_q.over_temp_150;
    // R13 R15 shutdown group
    logic shutdown_fault;
    assign shutdown_fault = ov_f | otp | flt_q.input_supply_low | flt_q.vcc_low
                          | flt_q.bootstrap_fault;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_INIT = 3'h0,
        ST_WAIT = 3'h1,
        ST_FILT = 3'h2,
        ST_BST = 3'h3,
        ST_SS = 3'h4,
        ST_BLANK = 3'h5,
        ST_RUN = 3'h6,
        ST_FAULT = 3'h7
    } state_e;

    state_e state_q;
    state_e state_d;
    logic [19:0] cnt_q; // Phase timer
    logic [19:0] cnt_d;
    logic [19:0] ss_len; // Selected ramp length
    logic [19:0] blank_len;
    logic blank_q; // Latched blanking select

    assign ss_len = (prog.ss_sel == SS_SEL_075) ? 20'(SS_075_CYC) :
                    (prog.ss_sel == SS_SEL_15) ? 20'(SS_15_CYC) :
                    (prog.ss_sel == SS_SEL_3) ? 20'(SS_3_CYC) : 20'(SS_6_CYC);
    assign blank_len = blank_q ? 20'(BLANK_LONG_CYC) : 20'(BLANK_SHORT_CYC);

    logic tmo_init;
    logic tmo_filt;
    logic tmo_bst;
    logic tmo_ss;
    logic tmo_blank;
    assign tmo_init = (cnt_q == 20'(INIT_CYC - 1));
    assign tmo_filt = (cnt_q == 20'(OE_FILT_CYC));
    assign tmo_bst = (cnt_q == 20'(BST_CYC - 1));
    assign tmo_ss = (cnt_q == ss_len - 20'h00001);
    assign tmo_blank = (cnt_q == blank_len - 20'h00001);

    // Next state logic
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 20'h00001;
        unique case (state_q)
            // R1 initialization phase
            ST_INIT: begin
                if (tmo_init) begin
                    state_d = ST_WAIT;
                    cnt_d = 20'h00000;
                end
            end
            ST_WAIT: begin
                cnt_d = 20'h00000;
                if (int_enable && !shutdown_fault) begin
                    state_d = ST_FILT;
                end
            end
            // R2 enable filter, short pulses dropped
            ST_FILT: begin
                if (!int_enable) begin
                    state_d = ST_WAIT;
                    cnt_d = 20'h00000;
                end else if (tmo_filt) begin
                    state_d = ST_BST;
                    cnt_d = 20'h00000;
                end
            end
            // R3 bootstrap charge
            ST_BST: begin
                if (tmo_bst) begin
                    state_d = ST_SS;
                    cnt_d = 20'h00000;
                end
            end
            // R4 soft start
            ST_SS: begin
                if (tmo_ss) begin
                    state_d = ST_BLANK;
                    cnt_d = 20'h00000;
                end
            end
            // R5 status blanking
            ST_BLANK: begin
                if (tmo_blank) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                cnt_d = cnt_q;
            end
            // R15 wait for clearance then restart
            ST_FAULT: begin
                cnt_d = 20'h00000;
                if (!shutdown_fault) begin
                    state_d = ST_WAIT;
                end
            end
        endcase
        // R15 shutdown faults override active phases
        if (state_q inside {ST_BST, ST_SS, ST_BLANK, ST_RUN} && shutdown_fault) begin
            state_d = ST_FAULT;
            cnt_d = 20'h00000;
        end
        // R24 enable loss aborts
        if (state_q inside {ST_BST, ST_SS, ST_BLANK, ST_RUN} && !int_enable) begin
            state_d = ST_WAIT;
            cnt_d = 20'h00000;
        end
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ST_INIT;
            cnt_q <= 20'h00000;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Programming latch, taken once at end of init
    // ------------------------------------------------------------
    prog_s prog_d;
    logic [3:0] ra_idx;
    logic [3:0] rb_idx;
    assign ra_idx = first_pin_resistor_code - RCODE_MIN;
    assign rb_idx = second_pin_resistor_code - RCODE_MIN;
    // R19 soft start and address
    assign prog_d.ss_sel = (first_pin_resistor_code > RCODE_SPLIT) ? SS_SEL_15 : SS_SEL_3;
    // Codes above the split wrap to low bits 000 to 011
    assign prog_d.bus_address = {ADDR_HIGH, ra_idx[2:0]};
    // R20 boot reference
    assign prog_d.boot_reference_level =
        (first_pin_capacitor_code == CCODE_220P) ? BOOT_REFERENCE_LEVEL_220_MV :
        (first_pin_capacitor_code == CCODE_1000P) ? BOOT_REFERENCE_LEVEL_1000_MV : BOOT_REFERENCE_LEVEL_OPEN_MV;
    // R21 gain and overcurrent setting
    assign prog_d.current_sense_gain =
        (second_pin_resistor_code <= RCODE_GAIN_B) ? GAIN_09 :
        (second_pin_resistor_code <= RCODE_SPLIT) ? GAIN_36 : GAIN_18;
    assign prog_d.ocp_setting = rb_idx[1:0];
    // R22 frequency
    assign prog_d.fsw_khz =
        (second_pin_capacitor_code == CCODE_220P) ? FSW_600 :
        (second_pin_capacitor_code == CCODE_1000P) ? FSW_800 : FSW_400;

    // R18 latch once at power up
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prog <= '0;
            blank_q <= 1'b0;
        end else if (state_q == ST_INIT && tmo_init) begin
            prog <= prog_d;
            blank_q <= blank_long_sel;
        end
    end

    // ------------------------------------------------------------
    // Reference ramp and output stage control
    // ------------------------------------------------------------
    logic ramping;
    assign ramping = (state_q == ST_SS);
    logic [35:0] ramp_num;
    assign ramp_num = 36'(cnt_q) * 36'(REF_FULL);
    logic [15:0] ramp_d;
    // R4 linear ramp from zero
    assign ramp_d = ramping ? 16'(ramp_num / 36'(ss_len)) :
                    (state_q inside {ST_BLANK, ST_RUN}) ? REF_FULL : 16'h0000;

    logic active;
    assign active = state_q inside {ST_SS, ST_BLANK, ST_RUN};
    logic sw_d;
    // R8 R9 residual voltage and R11 OV stop
    assign sw_d = active && !(ramping && (!res_below_s || res_above_s))
                  && !ov_f && !shutdown_fault;
    logic ocp_trip_q;
    // R12 hysteresis: primary trips, reduced releases
    logic ocp_d;
    assign ocp_d = flt_q.valley_over_primary | (ocp_trip_q & flt_q.valley_over_reduced);

    // R17 R10 R16 status window
    logic stat_ok;
    assign stat_ok = (state_q == ST_RUN) && !uv_f && !ov_f && !shutdown_fault
                     && !flt_q.sense_fault;

    // Registered outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bootstrap_node_charge <= 1'b0;
            switching_enable <= 1'b0;
            ocp_trip_q <= 1'b0;
            high_side_block <= 1'b0;
            reduced_current_limit <= 1'b0;
            ref_ramp <= 16'h0000;
            status_oe <= 1'b1;
        end else begin
            bootstrap_node_charge <= (state_q == ST_BST);
            switching_enable <= sw_d;
            ocp_trip_q <= ocp_d;
            high_side_block <= ocp_d;
            reduced_current_limit <= ocp_d;
            ref_ramp <= ramp_d;
            status_oe <= !stat_ok;
        end
    end
    assign status_out = 1'b0;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_init_wait: assert property (@(posedge clock) disable iff (rst) // R1
        (state_q == ST_INIT) |-> !bootstrap_node_charge)
        else $error("activity during init");
    a_filter_len: assert property (@(posedge clock) disable iff (rst) // R2
        (state_q == ST_FILT && state_d == ST_BST) |-> int_enable && tmo_filt)
        else $error("enable accepted early");
    a_bst_then_ss: assert property (@(posedge clock) disable iff (rst) // R3
        (state_q == ST_BST && state_d == ST_SS) |-> cnt_q == 20'(BST_CYC - 1))
        else $error("bootstrap length wrong");
    a_status_disabled: assert property (@(posedge clock) disable iff (rst) // R17
        (state_q == ST_WAIT) |=> status_oe)
        else $error("status released while disabled");
    a_ov_stops: assert property (@(posedge clock) disable iff (rst) // R11
        ov_f |=> !switching_enable && status_oe)
        else $error("overvoltage did not stop switching");
    a_uv_runs: assert property (@(posedge clock) disable iff (rst) // R10
        (uv_f && (state_q == ST_RUN || (ramping && res_below_s && !res_above_s))
         && !shutdown_fault && int_enable)
        |=> status_oe && switching_enable)
        else $error("undervoltage handling wrong");
    a_fault_shut: assert property (@(posedge clock) disable iff (rst) // R15
        (shutdown_fault && active) |=> state_q == ST_FAULT || state_q == ST_WAIT)
        else $error("shutdown fault ignored");
    a_enable_abort: assert property (@(posedge clock) disable iff (rst) // R24
        (!int_enable && active) |=> state_q == ST_WAIT)
        else $error("enable loss did not abort");
    a_ocp_block: assert property (@(posedge clock) disable iff (rst) // R12
        flt_q.valley_over_primary |=> high_side_block)
        else $error("overcurrent did not block");
    c_reach_run: cover property (@(posedge clock) disable iff (rst) state_q == ST_RUN);
    c_fault_restart: cover property (@(posedge clock) disable iff (rst)
        state_q == ST_FAULT ##1 state_q == ST_WAIT);
    c_short_pulse: cover property (@(posedge clock) disable iff (rst)
        state_q == ST_FILT ##1 state_q == ST_WAIT);
endmodule : regulator_startup_fault_sequencer

// ### test/host_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Host side: enable pin and bus operate bit
// ------------------------------------------------------------
module host_model (
    // Clock
    input wire logic clock,
    // Enable sources towards the block
    output logic enable_pin,
    output logic bus_operate
);
    // Both sources idle low at time zero
    initial begin
        enable_pin = 1'b0;
        bus_operate = 1'b0;
    end
    // Pin level, changed just after an edge
    task automatic set_pin(input logic v);
        @(posedge clock);
        #1 enable_pin = v;
    endtask : set_pin
    task automatic set_bus(input logic v);
        @(posedge clock);
        #1 bus_operate = v;
    endtask : set_bus
    // pin pulse of a given length
    task automatic pulse(input int n);
        set_pin(1'b1);
        repeat (n) @(posedge clock);
        #1 enable_pin = 1'b0;
    endtask : pulse
endmodule : host_model

// ### test/regulator_startup_fault_sequencer_tb.sv
`timescale 1ns/10ps
module regulator_startup_fault_sequencer_tb;
    import seq_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int LIMIT = 90000; // Cycle ceiling of the whole run
    localparam int SLACK = 8; // Sync and register latency allowance
    logic clock, rst, bus_otp_low_sel, blank_long_sel, residual_below_ref, residual_above_target;
    logic enable_pin, bus_operate, bootstrap_node, sw, hsb, rcl, status_out, status_oe;
    logic bst_q = 1'b0; // Previous bootstrap level
    logic [3:0] r1, r2; // Resistor codes
    logic [1:0] c1, c2; // Capacitor codes
    logic [15:0] ref_ramp;
    fault_s faults;
    prog_s prog, exp_prog;
    int cyc, rise_cyc, fall_cyc, n_fail, checked, seed, ss_len;
    int lo_q[$]; // Expected bootstrap start windows
    int hi_q[$];
    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    host_model i_host (.clock(clock), .enable_pin(enable_pin), .bus_operate(bus_operate));
    regulator_startup_fault_sequencer i_dut (
        .clock(clock), .rst(rst), .enable_pin(enable_pin), .bus_operate(bus_operate),
        .bus_otp_low_sel(bus_otp_low_sel), .first_pin_resistor_code(r1),
        .first_pin_capacitor_code(c1), .second_pin_resistor_code(r2),
        .second_pin_capacitor_code(c2), .blank_long_sel(blank_long_sel),
        .residual_below_ref(residual_below_ref), .residual_above_target(residual_above_target),
        .faults(faults), .bootstrap_node_charge(bootstrap_node), .switching_enable(sw),
        .high_side_block(hsb), .reduced_current_limit(rcl), .ref_ramp(ref_ramp),
        .status_out(status_out), .status_oe(status_oe), .prog(prog));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // Step just past rising edges
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    // Note a window for the next bootstrap start
    task automatic expect_bst(input int lo, input int hi);
        lo_q.push_back(cyc + lo);
        hi_q.push_back(cyc + hi);
    endtask : expect_bst
    // Bounded wait for a bootstrap level
    task automatic wait_bst(input logic v);
        int k;
        k = 0;
        while (bootstrap_node !== v && k < LIMIT) begin
            tick(1);
            k++;
        end
        check(bootstrap_node, v);
    endtask : wait_bst
    // Fault cleared: full sequence again
    task automatic restart;
        expect_bst(OE_FILT_CYC, OE_FILT_CYC + FAULT_FILT_CYC + 20);
        wait_bst(1'b1);
        wait_bst(1'b0);
        tick(SLACK);
    endtask : restart
    // Verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // Clock, cycle count and timeout
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Cycles since reset release; ceiling ends a hang
    always @(posedge clock) begin
        if (rst) begin
            cyc <= 0;
        end else begin
            cyc <= cyc + 1;
        end
        if (cyc >= LIMIT) begin
            n_fail++;
            results();
        end
    end
    // ------------------------------------------------------------
    // Watcher: bootstrap starts against noted windows
    // ------------------------------------------------------------
    always @(posedge clock) begin
        bst_q <= bootstrap_node;
        if (!rst && bootstrap_node === 1'b1 && bst_q === 1'b0) begin
            rise_cyc <= cyc;
            if (lo_q.size() == 0) begin
                check(1'b1, 1'b0);
            end else begin
                check(cyc >= lo_q[0] && cyc <= hi_q[0], 1'b1);
                void'(lo_q.pop_front());
                void'(hi_q.pop_front());
            end
        end
        if (!rst && bootstrap_node === 1'b0 && bst_q === 1'b1) begin
            fall_cyc <= cyc;
            check(cyc - rise_cyc, BST_CYC);
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        longint e;
        seed = 32'hF8CF;
        rst = 1'b1;
        {bus_otp_low_sel, blank_long_sel, residual_below_ref, residual_above_target} = 4'h0;
        faults = '0;
        r1 = 4'h1 + 4'($unsigned($random(seed)) % 12);
        r2 = 4'h1 + 4'($unsigned($random(seed)) % 12);
        c1 = 2'($unsigned($random(seed)) % 3);
        c2 = 2'($unsigned($random(seed)) % 3);
        ss_len = (r1 <= RCODE_SPLIT) ? SS_3_CYC : SS_15_CYC;
        exp_prog.bus_address = {ADDR_HIGH, 3'((r1 - 4'h1) % 8)};
        exp_prog.ss_sel = (r1 <= RCODE_SPLIT) ? SS_SEL_3 : SS_SEL_15;
        exp_prog.boot_reference_level = (c1 == CCODE_OPEN) ? BOOT_REFERENCE_LEVEL_OPEN_MV :
            (c1 == CCODE_220P) ? BOOT_REFERENCE_LEVEL_220_MV : BOOT_REFERENCE_LEVEL_1000_MV;
        exp_prog.current_sense_gain = (r2 <= RCODE_GAIN_B) ? GAIN_09 :
            (r2 <= RCODE_SPLIT) ? GAIN_36 : GAIN_18;
        exp_prog.ocp_setting = 2'((r2 - 4'h1) % 4);
        exp_prog.fsw_khz = (c2 == CCODE_OPEN) ? FSW_400 : (c2 == CCODE_220P) ? FSW_600 : FSW_800;
        // enable high through reset and init
        i_host.set_pin(1'b1);
        tick(10);
        check({status_out, status_oe}, 2'h1);
        tick(10);
        rst = 1'b0;
        expect_bst(INIT_CYC + OE_FILT_CYC, INIT_CYC + OE_FILT_CYC + SLACK);
        tick(100);
        check(prog, '0);
        check(bootstrap_node, 1'b0);
        tick(INIT_CYC + 10 - cyc);
        check(prog, exp_prog);
        r1 = 4'hC - r1 + 4'h1;
        c1 = 2'h2 - c1;
        wait_bst(1'b1);
        wait_bst(1'b0);
        tick(SLACK);
        check(sw, 1'b0);
        residual_below_ref = 1'b1;
        tick(SLACK);
        check(sw, 1'b1);
        tick(1000);
        check(status_oe, 1'b1);
        e = 64'd65535 * (cyc - fall_cyc) / ss_len;
        check(int'(ref_ramp) >= int'(e) - 4 && int'(ref_ramp) <= int'(e) + 4, 1'b1);
        faults.valley_over_primary = 1'b1;
        faults.valley_over_reduced = 1'b1;
        tick(SLACK);
        check({hsb, rcl}, 2'h3);
        faults.valley_over_primary = 1'b0;
        tick(SLACK);
        check(hsb, 1'b1);
        faults.valley_over_reduced = 1'b0;
        tick(SLACK);
        check(hsb, 1'b0);
        faults.output_undervoltage_detect = 1'b1;
        tick(FAULT_FILT_CYC + 16);
        check({sw, status_oe}, 2'h3);
        faults.output_undervoltage_detect = 1'b0;
        tick(FAULT_FILT_CYC + 16);
        faults.output_overvoltage_detect = 1'b1;
        tick(40);
        faults.output_overvoltage_detect = 1'b0;
        tick(10);
        check(sw, 1'b1);
        faults.output_overvoltage_detect = 1'b1;
        tick(FAULT_FILT_CYC + 16);
        check({sw, status_oe}, 2'h1);
        faults.output_overvoltage_detect = 1'b0;
        restart();
        i_host.set_pin(1'b0);
        tick(SLACK);
        check({sw, bootstrap_node, status_oe}, 3'h1);
        i_host.pulse(OE_FILT_CYC - 16);
        tick(OE_FILT_CYC + 50);
        // bus bit enables, pin takes over
        expect_bst(OE_FILT_CYC, OE_FILT_CYC + SLACK);
        i_host.set_bus(1'b1);
        wait_bst(1'b1);
        i_host.set_pin(1'b1);
        tick(4);
        i_host.set_bus(1'b0);
        wait_bst(1'b0);
        tick(SLACK);
        faults.input_supply_low = 1'b1;
        tick(SLACK);
        check({sw, status_oe}, 2'h1);
        faults.input_supply_low = 1'b0;
        restart();
        faults.over_temp_130 = 1'b1;
        tick(10);
        check(sw, 1'b1);
        bus_otp_low_sel = 1'b1;
        tick(SLACK);
        check({sw, status_oe}, 2'h1);
        faults.over_temp_130 = 1'b0;
        restart();
        check(prog, exp_prog);
        check(lo_q.size(), 0);
        results();
    end
endmodule : regulator_startup_fault_sequencer_tb
